// ---- logic/ovx_pkg.sv ----
// Purpose: Shared constants for the V/Hz overexcitation unit control block
// Assumes: 32-bit AHB-Lite register bus, 10 MHz clock
// Notes:   Offsets are byte addresses, one register per aligned word
package ovx_pkg;
  localparam int          UNITS        = 4;
  // Timing
  localparam int          CLK_NS       = 100;
  localparam int          TICK_NS      = 10_000_000;
  localparam int          TICK_CYCLES  = TICK_NS / CLK_NS;
  localparam int          TIME_W       = 16;
  localparam int          DIAL_W       = 10;
  // Register offsets
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_CLEAR    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_EN   = 8'h08;
  localparam logic [7:0]  OFS_STATE    = 8'h0C;
  localparam logic [3:0]  UNIT_FIRST   = 4'h1;
  localparam logic [3:0]  UNIT_LAST    = 4'h4;
  localparam logic [1:0]  SUB_CFG      = 2'h0;
  localparam logic [1:0]  SUB_DELAY    = 2'h1;
  localparam logic [1:0]  SUB_DIAL     = 2'h2;
  // Unit config fields
  localparam int          CFG_CMD_EN   = 0;
  localparam int          CFG_PIN_SRC  = 1;
  localparam int          CFG_CURVE    = 2;
  localparam logic [2:0]  CFG_RESET    = 3'h1;
  localparam logic [15:0] DELAY_RESET  = 16'h0064;
  localparam logic [9:0]  DIAL_RESET   = 10'h00A;
  // Event and state field bases
  localparam int          EV_PICKUP    = 0;
  localparam int          EV_TRIP      = 4;
  localparam int          EV_BLOCK     = 8;
  localparam int          EV_ENABLE    = 12;
  localparam int          ST_SERVICE   = 8;
  localparam int          ST_BLOCK     = 12;
  localparam int          ST_ENABLE    = 16;
  localparam int          EV_W         = 16;
  // Timing type codes
  localparam logic        CURVE_DEF    = 1'b0;
  localparam logic        CURVE_INV    = 1'b1;
endpackage

// ---- logic/ovx_top.sv ----
// Purpose: Four-unit V/Hz overexcitation control with AHB-Lite registers
// Assumes: Contact inputs asynchronous; measurement inputs on CLK_I
// Notes:   Zero-wait slave; read data registered in the address phase
// Contract
// - Blocking before trip keeps the unit from tripping while it stays.
// - Blocking after trip clears the unit's trip output.
// - Unit in service only while enable active; else no pickup or trip.
// - Undriven enable counts as one; unit in service by default.
// - Enable comes from a contact level or from a command.
// - Pickup asserts the pickup output and starts the operate timer together.
// - Four independent units, each with its own inputs and outputs. The code shares one VOLT_INHIBIT_I input across all four.
// - Separate trip per unit, when its timer completes with pickup held.
// - Per-unit status output shows enabled or disabled.
// - Blocking and enable inputs reported as outputs and events.
// - Pickup above 1.05 times set ratio, drops below set value.
// - Trip needs pickup for the whole delay; dropout restarts timer.
// - No trip while voltage is below the inhibit setting.
// - Timing type 0 uses the delay, type 1 the inverse curve.
`timescale 1ns/1ns
module ovx_top #(
  parameter int TICK_CYCLES = ovx_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                  CLK_I,
  input  wire logic                                  SYS_RST_I,
  // AHB-Lite slave
  input  wire logic                                  HSEL_I,
  input  wire logic [31:0]                           HADDR_I,
  input  wire logic [1:0]                            HTRANS_I,
  input  wire logic                                  HWRITE_I,
  input  wire logic [2:0]                            HSIZE_I,
  input  wire logic [31:0]                           HWDATA_I,
  input  wire logic                                  HREADY_I,
  output logic      [31:0]                           HRDATA_O,
  output logic                                       HREADYOUT_O,
  output logic                                       HRESP_O,
  // Contact inputs, asynchronous
  input  wire logic [ovx_pkg::UNITS-1:0]             VHZ_BLOCK_IN_I,
  input  wire logic [ovx_pkg::UNITS-1:0]             VHZ_ENABLE_IN_I,
  // Measurement, on CLK_I
  input  wire logic [ovx_pkg::UNITS-1:0]             VHZ_ABOVE_PU_I,
  input  wire logic [ovx_pkg::UNITS-1:0]             VHZ_ABOVE_SET_I,
  input  wire logic                                  VOLT_INHIBIT_I,
  input  wire logic [ovx_pkg::UNITS*ovx_pkg::TIME_W-1:0] INV_TIME_I,
  // Unit outputs
  output logic      [ovx_pkg::UNITS-1:0]             VHZ_PICKUP_OUT_O,
  output logic      [ovx_pkg::UNITS-1:0]             VHZ_TRIP_OUT_O,
  output logic      [ovx_pkg::UNITS-1:0]             VHZ_IN_SERVICE_O,
  output logic      [ovx_pkg::UNITS-1:0]             VHZ_BLOCK_OUT_O,
  output logic      [ovx_pkg::UNITS-1:0]             VHZ_ENABLE_OUT_O,
  // Curve arithmetic settings
  output logic      [ovx_pkg::UNITS-1:0]             CURVE_O,
  output logic      [ovx_pkg::UNITS*ovx_pkg::DIAL_W-1:0] DIAL_O,
  // Interrupt
  output logic                                       IRQ_O
);
  localparam int N  = ovx_pkg::UNITS;
  localparam int TW = ovx_pkg::TIME_W;
  localparam int DW = ovx_pkg::DIAL_W;
  localparam int EW = ovx_pkg::EV_W;

  // Divider for the 10 ms timer tick
  logic [31:0]         div_r;
  logic                tick_r;
  wire                 div_end = div_r == 32'(TICK_CYCLES - 1);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      div_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_end ? 32'h0000_0000 : div_r + 32'h0000_0001;
      tick_r <= div_end;
    end
  end

  // Contact synchronisers
  logic [N-1:0]        blk_s1_r;
  logic [N-1:0]        blk_s2_r;
  logic [N-1:0]        enp_s1_r;
  logic [N-1:0]        enp_s2_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      blk_s1_r <= '0;
      blk_s2_r <= '0;
      enp_s1_r <= '0;
      enp_s2_r <= '0;
    end else begin
      blk_s1_r <= VHZ_BLOCK_IN_I;
      blk_s2_r <= blk_s1_r;
      enp_s1_r <= VHZ_ENABLE_IN_I;
      enp_s2_r <= enp_s1_r;
    end
  end

  // Unit settings
  logic [2:0]          cfg_r   [N];
  logic [TW-1:0]       delay_r [N];
  logic [DW-1:0]       dial_r  [N];
  logic [N-1:0]        en_eff;
  logic [N-1:0]        pickup;
  logic [N-1:0]        trip;
  logic [TW-1:0]       limit   [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      // Pin source or command; the command defaults to one
      assign en_eff[g] = cfg_r[g][ovx_pkg::CFG_PIN_SRC] ? enp_s2_r[g]
                                                        : cfg_r[g][ovx_pkg::CFG_CMD_EN];
      assign limit[g]  = (cfg_r[g][ovx_pkg::CFG_CURVE] == ovx_pkg::CURVE_INV)
                         ? INV_TIME_I[g*TW +: TW] : delay_r[g];
      assign CURVE_O[g]          = cfg_r[g][ovx_pkg::CFG_CURVE];
      assign DIAL_O[g*DW +: DW]  = dial_r[g];

      ovx_unit u_unit (
        .clk_i     (CLK_I),
        .rst_i     (SYS_RST_I),
        .tick_i    (tick_r),
        .svc_i     (en_eff[g]),
        .blk_i     (blk_s2_r[g]),
        .inhibit_i (VOLT_INHIBIT_I),
        .limit_i   (limit[g]),
        .pu_hi_i   (VHZ_ABOVE_PU_I[g]),
        .pu_lo_i   (VHZ_ABOVE_SET_I[g]),
        .pickup_o  (pickup[g]),
        .trip_o    (trip[g])
      );
    end
  endgenerate

  // Registered unit outputs, one cycle behind the unit state
  logic [N-1:0]        pickup_out_r;
  logic [N-1:0]        trip_out_r;
  logic [N-1:0]        svc_out_r;
  logic [N-1:0]        blk_out_r;
  logic [N-1:0]        en_out_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pickup_out_r <= '0;
      trip_out_r   <= '0;
      svc_out_r    <= '0;
      blk_out_r    <= '0;
      en_out_r     <= '0;
    end else begin
      pickup_out_r <= pickup;
      trip_out_r   <= trip;
      svc_out_r    <= en_eff;
      blk_out_r    <= blk_s2_r;
      en_out_r     <= en_eff;
    end
  end

  assign VHZ_PICKUP_OUT_O = pickup_out_r;
  assign VHZ_TRIP_OUT_O   = trip_out_r;
  assign VHZ_IN_SERVICE_O = svc_out_r;
  assign VHZ_BLOCK_OUT_O  = blk_out_r;
  assign VHZ_ENABLE_OUT_O = en_out_r;

  // Enable reference resets to the default enable, so leaving reset is no event
  logic [N-1:0]        en_prev_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      en_prev_r <= {N{ovx_pkg::CFG_RESET[ovx_pkg::CFG_CMD_EN]}};
    end else begin
      en_prev_r <= en_eff;
    end
  end

  // Events: rising pickup and trip, any change of block or enable
  wire [EW-1:0]        events = {en_prev_r ^ en_eff, blk_out_r ^ blk_s2_r,
                                 trip & ~trip_out_r, pickup & ~pickup_out_r};

  // AHB-Lite address phase
  wire                 ahb_go  = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire                 ahb_wr  = ahb_go & HWRITE_I;
  wire                 ahb_rd  = ahb_go & ~HWRITE_I;
  logic                wr_pend_r;
  logic [7:0]          wr_addr_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_wr;
      wr_addr_r <= ahb_wr ? HADDR_I[7:0] : wr_addr_r;
    end
  end

  // Data phase write decode
  wire [3:0]           w_blk   = wr_addr_r[7:4];
  wire [1:0]           w_sub   = wr_addr_r[3:2];
  wire [1:0]           w_unit  = 2'(w_blk - ovx_pkg::UNIT_FIRST);
  wire                 w_inu   = wr_pend_r && w_blk >= ovx_pkg::UNIT_FIRST && w_blk <= ovx_pkg::UNIT_LAST;
  wire                 w_clear = wr_pend_r && wr_addr_r == ovx_pkg::OFS_CLEAR;
  wire                 w_irqen = wr_pend_r && wr_addr_r == ovx_pkg::OFS_IRQ_EN;
  wire                 w_cfg   = w_inu && w_sub == ovx_pkg::SUB_CFG;
  wire                 w_delay = w_inu && w_sub == ovx_pkg::SUB_DELAY;
  wire                 w_dial  = w_inu && w_sub == ovx_pkg::SUB_DIAL;

  // Interrupt status, set wins over clear
  logic [EW-1:0]       status_r;
  logic [EW-1:0]       irq_en_r;
  wire  [EW-1:0]       clr_mask = w_clear ? HWDATA_I[EW-1:0] : '0;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      status_r <= '0;
      irq_en_r <= '0;
    end else begin
      status_r <= (status_r & ~clr_mask) | events;
      irq_en_r <= w_irqen ? HWDATA_I[EW-1:0] : irq_en_r;
    end
  end

  assign IRQ_O = |(status_r & irq_en_r);

  // Unit setting registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < N; i++) begin
        cfg_r[i]   <= ovx_pkg::CFG_RESET;
        delay_r[i] <= ovx_pkg::DELAY_RESET;
        dial_r[i]  <= ovx_pkg::DIAL_RESET;
      end
    end else begin
      if (w_cfg) begin
        cfg_r[w_unit] <= HWDATA_I[2:0];
      end
      if (w_delay) begin
        delay_r[w_unit] <= HWDATA_I[TW-1:0];
      end
      if (w_dial) begin
        dial_r[w_unit] <= HWDATA_I[DW-1:0];
      end
    end
  end

  // Read decode in the address phase
  wire [7:0]           r_addr  = HADDR_I[7:0];
  wire [3:0]           r_blk   = r_addr[7:4];
  wire [1:0]           r_sub   = r_addr[3:2];
  wire [1:0]           r_unit  = 2'(r_blk - ovx_pkg::UNIT_FIRST);
  wire                 r_inu   = r_blk >= ovx_pkg::UNIT_FIRST && r_blk <= ovx_pkg::UNIT_LAST;
  wire [31:0]          state_w = {12'h000, en_eff, blk_s2_r, en_eff, trip, pickup};
  logic [31:0]         rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (r_addr == ovx_pkg::OFS_STATUS) begin
      rd_mux = {16'h0000, status_r};
    end else if (r_addr == ovx_pkg::OFS_IRQ_EN) begin
      rd_mux = {16'h0000, irq_en_r};
    end else if (r_addr == ovx_pkg::OFS_STATE) begin
      rd_mux = state_w;
    end else if (r_inu && r_sub == ovx_pkg::SUB_CFG) begin
      rd_mux = {29'h0000_0000, cfg_r[r_unit]};
    end else if (r_inu && r_sub == ovx_pkg::SUB_DELAY) begin
      rd_mux = {16'h0000, delay_r[r_unit]};
    end else if (r_inu && r_sub == ovx_pkg::SUB_DIAL) begin
      rd_mux = {22'h00_0000, dial_r[r_unit]};
    end
  end

  logic [31:0]         rdata_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (ahb_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Zero wait states; unmapped reads give zero, writes are dropped
  assign HRDATA_O    = rdata_r;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  default clocking tcb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  default_on_a: assert property ($fell(SYS_RST_I) |=> &VHZ_IN_SERVICE_O)
    else $error("units not in service after reset");
  pin_source_a: assert property (cfg_r[2][ovx_pkg::CFG_PIN_SRC] && $past(cfg_r[2][ovx_pkg::CFG_PIN_SRC], 3)
                                 |-> en_eff[2] == $past(VHZ_ENABLE_IN_I[2], 2))
    else $error("enable does not follow contact");
  status_out_a: assert property (!$past(SYS_RST_I) |-> VHZ_IN_SERVICE_O == $past(en_eff))
    else $error("in-service output wrong");
  block_report_a: assert property (VHZ_BLOCK_IN_I[1] [*4] |-> VHZ_BLOCK_OUT_O[1] || $past(SYS_RST_I, 3))
    else $error("block not reported");
  curve_select_a: assert property (cfg_r[2][ovx_pkg::CFG_CURVE] == ovx_pkg::CURVE_DEF |-> limit[2] == delay_r[2])
    else $error("definite time not used");
  trip_report_a: assert property ($rose(trip[3]) |=> VHZ_TRIP_OUT_O[3] && status_r[ovx_pkg::EV_TRIP + 3])
    else $error("trip not reported");
  irq_raise_c: cover property ($rose(IRQ_O));
  pin_disable_c: cover property (cfg_r[2][ovx_pkg::CFG_PIN_SRC] && !en_eff[2]);
endmodule

// ---- logic/ovx_unit.sv ----
// Purpose: One overexcitation unit: pickup hysteresis, operate timer, trip
// Assumes: tick_i is a one-cycle 10 ms pulse
// Notes:   Trip falls with pickup; a disabled or blocked unit holds nothing
`timescale 1ns/1ns
module ovx_unit (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        tick_i,
  // Control
  input  wire logic                        svc_i,
  input  wire logic                        blk_i,
  input  wire logic                        inhibit_i,
  input  wire logic [ovx_pkg::TIME_W-1:0]  limit_i,
  // Measurement
  input  wire logic                        pu_hi_i,
  input  wire logic                        pu_lo_i,
  // Outputs
  output logic                             pickup_o,
  output logic                             trip_o
);
  logic                        pickup_r;
  logic                        pickup_nxt;
  logic                        trip_r;
  logic                        trip_nxt;
  logic [ovx_pkg::TIME_W-1:0]  cnt_r;
  logic [ovx_pkg::TIME_W-1:0]  cnt_nxt;
  wire                         act      = svc_i & ~blk_i;
  wire                         expired  = cnt_r >= limit_i;

  // Set above 1.05x, hold until below set value
  assign pickup_nxt = act & (pu_hi_i | (pickup_r & pu_lo_i));
  // Count only while picked up; a dropout restarts from zero
  assign cnt_nxt = !(act & pickup_r) ? '0 :
                   (tick_i && !expired) ? cnt_r + 1'b1 : cnt_r;
  // Block before trip prevents it, block after trip clears it
  assign trip_nxt = act & pickup_r & pickup_nxt & expired & ~inhibit_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pickup_r <= 1'b0;
      trip_r   <= 1'b0;
      cnt_r    <= '0;
    end else begin
      pickup_r <= pickup_nxt;
      trip_r   <= trip_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign pickup_o = pickup_r;
  assign trip_o   = trip_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  blocked_no_trip_a: assert property (blk_i |=> !trip_r)
    else $error("trip while blocked");
  block_clears_a: assert property (trip_r && blk_i |=> !trip_r && !pickup_r)
    else $error("block did not clear trip");
  disabled_quiet_a: assert property (!svc_i |=> !pickup_r && !trip_r && cnt_r == '0)
    else $error("disabled unit active");
  timer_runs_a: assert property (act && pickup_r && tick_i && !expired |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("timer did not advance");
  trip_cause_a: assert property ($rose(trip_r) |-> $past(pickup_r && expired && !inhibit_i))
    else $error("trip without expired timer");
  dropout_restart_a: assert property (!pickup_r |=> cnt_r == '0)
    else $error("timer not restarted");
  inhibit_trip_a: assert property (inhibit_i |=> !trip_r)
    else $error("trip under inhibit voltage");
  pickup_set_a: assert property (act && pu_hi_i |=> pickup_r)
    else $error("pickup missed");
  pickup_drop_a: assert property (pickup_r && !pu_lo_i && !pu_hi_i |=> !pickup_r)
    else $error("pickup did not drop");
  trip_seen_c: cover property ($rose(trip_r));
  block_after_trip_c: cover property (trip_r && blk_i ##1 !trip_r);
  dropout_mid_c: cover property (pickup_r && cnt_r != '0 ##1 !pickup_r);
endmodule

// ---- verif/overexcitation_unit_control_bench.sv ----
// Purpose: Self-checking bench for the four-unit V/Hz control block
// Assumes: Tick shortened to 4 clocks; one register access at a time
// Notes:   Outputs sampled on falling edges except HRDATA_O, HREADYOUT_O and DIAL_O, read on rising; inputs driven on rising edges
`timescale 1ns/1ns
module overexcitation_unit_control_bench;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [3:0]  blk_req   = 4'h0;
  logic [3:0]  en_req    = 4'hF;
  logic [7:0]  lvl_req   = 8'h00;
  logic        inhibit   = 1'b0;
  logic [63:0] inv_time  = 64'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [3:0]  blk_pin, en_pin, above_pu, above_set;
  logic [3:0]  pickup, trip, in_svc, blk_out, en_out, curve;
  logic [39:0] dial;
  int          errors    = 0;
  int          cmp_count = 0;

  always #50 clk = ~clk;

  ovx_field_model field (.clk_i(clk), .blk_req_i(blk_req), .en_req_i(en_req), .lvl_req_i(lvl_req),
    .block_o(blk_pin), .enable_o(en_pin), .above_pu_o(above_pu), .above_set_o(above_set));

  ovx_top #(.TICK_CYCLES(4)) uut (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .VHZ_BLOCK_IN_I(blk_pin),
    .VHZ_ENABLE_IN_I(en_pin), .VHZ_ABOVE_PU_I(above_pu), .VHZ_ABOVE_SET_I(above_set),
    .VOLT_INHIBIT_I(inhibit), .INV_TIME_I(inv_time), .VHZ_PICKUP_OUT_O(pickup), .VHZ_TRIP_OUT_O(trip),
    .VHZ_IN_SERVICE_O(in_svc), .VHZ_BLOCK_OUT_O(blk_out), .VHZ_ENABLE_OUT_O(en_out), .CURVE_O(curve),
    .DIAL_O(dial), .IRQ_O(irq));

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Single word transfer; no wait count assumed, the watchdog ends a hang
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task wait_out(input logic want_trip, input int u);
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if ((want_trip ? trip[u] : pickup[u]) === 1'b1) break;
    end
  endtask

  task final_report;
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task t_reset;
    @(negedge clk);
    chk("in_service", 32'hF, in_svc);
    chk("pickup", 32'h0, pickup);
    chk("hresp", 32'h0, hresp);
    ahb(1'b0, 32'h00, 32'h0);
    chk("status", 32'h0, rd);
    ahb(1'b0, 32'h10, 32'h0);
    chk("cfg", 32'h1, rd);
    ahb(1'b0, 32'h14, 32'h0);
    chk("delay", 32'h64, rd);
    ahb(1'b0, 32'h18, 32'h0);
    chk("dial", 32'h0A, rd);
    chk("dial_o", 32'h0A, dial[9:0]);
    ahb(1'b0, 32'hF0, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask

  task t_trip;
    ahb(1'b1, 32'h14, 32'h1);
    ahb(1'b1, 32'h08, 32'h10);
    ahb(1'b0, 32'h08, 32'h0);
    chk("irq_en", 32'h10, rd);
    lvl_req[1:0] <= 2'h2;
    wait_out(1'b0, 0);
    chk("pickup", 32'h1, pickup);
    chk("trip", 32'h0, trip);
    wait_out(1'b1, 0);
    chk("trip", 32'h1, trip);
    chk("irq", 32'h1, irq);
    ahb(1'b0, 32'h00, 32'h0);
    chk("status", 32'h11, rd & 32'h00FF);
    ahb(1'b1, 32'h04, 32'hFFFF);
    @(negedge clk);
    chk("irq", 32'h0, irq);
    @(posedge clk) blk_req[0] <= 1'b1;
    cyc(5);
    @(negedge clk);
    chk("trip", 32'h0, trip);
    chk("pickup", 32'h0, pickup);
    chk("block_out", 32'h1, blk_out);
    ahb(1'b0, 32'h00, 32'h0);
    chk("status", 32'h100, rd & 32'h0F00);
    blk_req[0] <= 1'b0;
    lvl_req[1:0] <= 2'h0;
  endtask

  task t_block;
    ahb(1'b1, 32'h24, 32'h1);
    blk_req[1] <= 1'b1;
    cyc(5);
    lvl_req[3:2] <= 2'h2;
    cyc(40);
    @(negedge clk);
    chk("unit1", 32'h0, {pickup[1], trip[1]});
    @(posedge clk) blk_req[1] <= 1'b0;
    wait_out(1'b1, 1);
    chk("trip", 32'h2, trip);
    @(posedge clk) lvl_req[3:2] <= 2'h0;
  endtask

  task t_enable;
    ahb(1'b1, 32'h30, 32'h3);
    en_req[2] <= 1'b0;
    lvl_req[5:4] <= 2'h2;
    cyc(40);
    @(negedge clk);
    chk("in_service", 32'hB, in_svc);
    chk("enable_out", 32'hB, en_out);
    chk("pickup", 32'h0, pickup);
    @(posedge clk) en_req[2] <= 1'b1;
    wait_out(1'b0, 2);
    chk("pickup", 32'h4, pickup);
    ahb(1'b1, 32'h30, 32'h0);
    cyc(3);
    @(negedge clk);
    chk("in_service", 32'hB, in_svc);
    chk("pickup", 32'h0, pickup);
    @(posedge clk) lvl_req[5:4] <= 2'h0;
    ahb(1'b1, 32'h30, 32'h1);
  endtask

  task t_inhibit;
    ahb(1'b1, 32'h44, 32'h1);
    inhibit <= 1'b1;
    lvl_req[7:6] <= 2'h2;
    cyc(40);
    @(negedge clk);
    chk("pickup", 32'h8, pickup);
    chk("trip", 32'h0, trip);
    ahb(1'b0, 32'h0C, 32'h0);
    chk("state", 32'h000F_0F08, rd);
    @(posedge clk) inhibit <= 1'b0;
    wait_out(1'b1, 3);
    chk("trip", 32'h8, trip);
    @(posedge clk) lvl_req[7:6] <= 2'h0;
  endtask

  // Inverse limit 5 ticks against a delay of 1 tick; dropout mid-count
  task t_curve;
    ahb(1'b1, 32'h10, 32'h5);
    inv_time[15:0] <= 16'h0005;
    lvl_req[1:0] <= 2'h2;
    wait_out(1'b0, 0);
    chk("curve", 32'h1, curve);
    repeat (12) @(negedge clk);
    chk("trip", 32'h0, trip);
    @(posedge clk) lvl_req[1:0] <= 2'h0;
    cyc(4);
    lvl_req[1:0] <= 2'h2;
    wait_out(1'b0, 0);
    repeat (14) @(negedge clk);
    chk("trip", 32'h0, trip);
    wait_out(1'b1, 0);
    chk("trip", 32'h1, trip);
    @(posedge clk) lvl_req[1:0] <= 2'h0;
  endtask

  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    t_reset;
    t_trip;
    t_block;
    t_enable;
    t_inhibit;
    t_curve;
    final_report;
  end

  // Whole run is well under a thousand clocks
  initial begin
    #(100 * 5000);
    errors++;
    final_report;
  end
endmodule

// ---- verif/ovx_field_model.sv ----
// Purpose: Field side of the relay: contact levels and V/Hz comparator pair
// Assumes: Bench requests change on CLK_I rising edges
// Notes:   Above pickup always implies above set, so hysteresis order holds
`timescale 1ns/1ns
module ovx_field_model (
  // Clock
  input  wire logic       clk_i,
  // Requests from the bench
  input  wire logic [3:0] blk_req_i,
  input  wire logic [3:0] en_req_i,
  input  wire logic [7:0] lvl_req_i,
  // Pins toward the relay
  output logic      [3:0] block_o,
  output logic      [3:0] enable_o,
  output logic      [3:0] above_pu_o,
  output logic      [3:0] above_set_o
);
  // Level code per unit: 0 below set, 1 between, 2 above pickup
  always_ff @(posedge clk_i) begin
    block_o  <= blk_req_i;
    enable_o <= en_req_i;
    for (int u = 0; u < 4; u++) begin
      above_pu_o[u]  <= lvl_req_i[2*u+1];
      above_set_o[u] <= |lvl_req_i[2*u +: 2];
    end
  end
endmodule
